// >>> hw/frm_pkg.sv
package frm_pkg;
   // Register byte addresses, one 32-bit word each
   localparam logic [7:0] A_CTRL     = 8'h00;
   localparam logic [7:0] A_VOL_RCP  = 8'h04;
   localparam logic [7:0] A_RSCALE   = 8'h08;
   localparam logic [7:0] A_FULL20   = 8'h0c;
   localparam logic [7:0] A_ALARM_SP = 8'h10;
   localparam logic [7:0] A_CUTOFF   = 8'h14;
   localparam logic [7:0] A_HOLDOFF  = 8'h18;
   localparam logic [7:0] A_CYCLES   = 8'h1c;
   localparam logic [7:0] A_RDELAY   = 8'h20;
   localparam logic [7:0] A_ROUTE    = 8'h24;
   localparam logic [7:0] A_STATUS   = 8'h28;
   localparam logic [7:0] A_MASK     = 8'h2c;
   localparam logic [7:0] A_RATE     = 8'h30;
   localparam logic [7:0] A_TOT_LO   = 8'h34;
   localparam logic [7:0] A_TOT_HI   = 8'h38;
   localparam logic [7:0] A_SEQ      = 8'h3c;
   localparam logic [7:0] A_DISP     = 8'h40;

   // Control word fields
   localparam int CTRL_W   = 15;
   localparam int SEL_BIT  = 0;
   localparam int TB_LSB   = 1;
   localparam int AUTO_BIT = 3;
   localparam int SM_LSB   = 4;
   localparam int JO_LSB   = 8;
   localparam int DP_LSB   = 12;
   localparam logic [CTRL_W-1:0] CTRL_RST = 15'h0000;

   localparam logic [1:0] TB_SEC = 2'h0;
   localparam logic [1:0] TB_MIN = 2'h1;
   localparam logic [1:0] TB_HR  = 2'h2;
   localparam logic [11:0] TB_MIN_MUL = 12'd60;
   localparam logic [11:0] TB_HR_MUL  = 12'd3600;
   // Reciprocals of the timebase divisors, Q0.24
   localparam logic [24:0] TB_RCP_SEC = 25'h1000000;
   localparam logic [24:0] TB_RCP_MIN = 25'(16777216 / 60);
   localparam logic [24:0] TB_RCP_HR  = 25'(16777216 / 3600);

   // Fixed point: rate and setpoints Q20.12, volume per pulse Q12.20
   localparam logic [31:0] ONE_Q12 = 32'h00001000;
   localparam logic [31:0] ONE_Q20 = 32'h00100000;

   localparam logic [31:0] MAX_CYCLES  = 32'd10000;
   localparam logic [31:0] MIN_HOLDOFF = 32'd1;
   localparam logic [31:0] MAX_HOLDOFF = 32'd3600;
   localparam logic [31:0] MAX_RDELAY  = 32'd86400;
   localparam logic [31:0] MAX_SETTING = 32'd9;
   localparam logic [31:0] MAX_DP      = 32'd7;

   localparam int ST_W       = 4;
   localparam int ST_LOWFLOW = 0;
   localparam int ST_AUTOST  = 1;
   localparam int ST_CYCDONE = 2;
   localparam int ST_CUTOFF  = 3;

   // Timing
   localparam int CLK_PERIOD_NS = 8;
   localparam int SEC_NS        = 1000000000;
   localparam int SEC_CYC       = SEC_NS / CLK_PERIOD_NS;
   localparam int FILT_TICK_MS  = 100;
   localparam int FILT_CYC      = FILT_TICK_MS * 1000000 / CLK_PERIOD_NS;

   // Smoothing time constants in tenths of a second
   localparam int TAU1 = 13;
   localparam int TAU2 = 43;
   localparam int TAU3 = 65;
   localparam int TAU4 = 87;
   localparam int TAU5 = 113;
   localparam int TAU6 = 157;
   localparam int TAU7 = 209;
   localparam int TAU8 = 252;
   localparam int TAU9 = 315;
   // alpha = tick / tau in Q16
   localparam int ALPHA_NUM = 65536 * FILT_TICK_MS / 100;

   function automatic logic [16:0] alpha_q16(input logic [3:0] s);
      unique case (s)
         4'h1:    return 17'(ALPHA_NUM / TAU1);
         4'h2:    return 17'(ALPHA_NUM / TAU2);
         4'h3:    return 17'(ALPHA_NUM / TAU3);
         4'h4:    return 17'(ALPHA_NUM / TAU4);
         4'h5:    return 17'(ALPHA_NUM / TAU5);
         4'h6:    return 17'(ALPHA_NUM / TAU6);
         4'h7:    return 17'(ALPHA_NUM / TAU7);
         4'h8:    return 17'(ALPHA_NUM / TAU8);
         4'h9:    return 17'(ALPHA_NUM / TAU9);
         default: return 17'h10000;
      endcase
   endfunction

   function automatic logic [6:0] jump_pct(input logic [3:0] j);
      unique case (j)
         4'h1:    return 7'd1;
         4'h2:    return 7'd2;
         4'h3:    return 7'd4;
         4'h4:    return 7'd8;
         4'h5:    return 7'd12;
         4'h6:    return 7'd16;
         4'h7:    return 7'd24;
         4'h8:    return 7'd32;
         4'h9:    return 7'd64;
         default: return 7'd0;
      endcase
   endfunction

   localparam logic [6:0] PCT_FULL = 7'd100;

   typedef enum logic [1:0] {SEQ_IDLE, SEQ_RUN, SEQ_DELAY} seq_e;
endpackage

// >>> hw/filt_if.sv
interface filt_if;
   logic        tick;
   logic [31:0] x;
   logic [31:0] y;
   logic [3:0]  smooth;
   logic [3:0]  jump;
   modport filt (input tick, x, smooth, jump, output y);
   modport user (output tick, x, smooth, jump, input y);
endinterface

// >>> hw/rate_filter.sv
module rate_filter (
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic ce,
   // Filter channel
   filt_if.filt      f
);
   logic signed [32:0] diff;
   logic        [31:0] mag;
   logic signed [50:0] step;
   logic               jump_hit;

   always_comb begin
      diff     = $signed({1'b0, f.x}) - $signed({1'b0, f.y});
      mag      = diff[32] ? 32'(-diff) : diff[31:0];
      step     = (51'(diff) * $signed({1'b0, frm_pkg::alpha_q16(f.smooth)})) >>> 16;
      jump_hit = (f.jump != 4'h0) &&
                 (40'(mag) * 40'(frm_pkg::PCT_FULL) >
                  40'(f.y) * 40'(frm_pkg::jump_pct(f.jump)));
   end

   // First-order smoothing, bypassed on a large step
   always_ff @(posedge clk) begin
      if (rst) begin
         f.y <= 32'h0;
      end else if (ce && f.tick) begin
         if (f.smooth == 4'h0) begin
            f.y <= f.x;
         end else if (jump_hit) begin
            f.y <= f.x;
         end else begin
            f.y <= 32'($signed({1'b0, f.y}) + step);
         end
      end
   end
endmodule

// >>> hw/flow_rate_monitor.sv
// Our own choices: the register offsets and the plain strobed port.
module flow_rate_monitor #(
   parameter int          NSW      = 6,
   parameter int          ADC_W    = 16,
   parameter int          CNT_W    = 24,
   parameter logic [15:0] CODE_4MA  = 16'h0ccd,
   parameter logic [15:0] CODE_20MA = 16'h4000,
   parameter int          SEC_CYC  = frm_pkg::SEC_CYC,
   parameter int          FILT_CYC = frm_pkg::FILT_CYC
) (
   // Clock, reset, enable
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic             ce,
   // Flowmeter inputs
   input  wire logic             pulse_in,
   input  wire logic [ADC_W-1:0] adc_code,
   // Batch control events
   input  wire logic             batch_start,
   input  wire logic             batch_done,
   // Register port
   input  wire logic [7:0]       addr,
   input  wire logic [31:0]      wdata,
   input  wire logic             wr,
   input  wire logic             rd,
   output logic      [31:0]      rdata,
   // Results
   output logic      [31:0]      rate_value,
   output logic      [31:0]      rate_disp,
   output logic      [3:0]       rate_digits,
   output logic      [47:0]      total,
   output logic      [NSW-1:0]   alarm_sw,
   output logic                  low_flow_pause,
   output logic                  auto_start,
   output logic                  irq
);
   localparam logic [47:0] INV_SPAN = 48'((64'h1 << 24) / (CODE_20MA - CODE_4MA));

   logic [frm_pkg::CTRL_W-1:0] ctrl;
   logic [31:0]      vol_rcp, rscale, full20, alarm_sp, cutoff;
   logic [11:0]      holdoff;
   logic [13:0]      cycles;
   logic [16:0]      rdelay;
   logic [NSW-1:0]   route;
   logic [frm_pkg::ST_W-1:0] status, irq_mask, ev;
   logic [31:0]      sec_cnt, filt_cnt;
   logic             sec_tick, filt_tick;
   logic             pulse_d;
   logic [CNT_W-1:0] pcnt;
   logic [31:0]      p_rate, a_rate;
   logic             running;
   logic [11:0]      hold_cnt;
   logic [13:0]      done_cnt;
   logic [16:0]      dly_cnt;
   logic             cut_d;
   frm_pkg::seq_e    seq;

   filt_if fch ();

   function automatic logic [31:0] clamp(input logic [31:0] v, input logic [31:0] lo,
                                          input logic [31:0] hi);
      return (v < lo) ? lo : ((v > hi) ? hi : v);
   endfunction

   function automatic logic [23:0] pow10(input logic [2:0] n);
      logic [23:0] p;
      p = 24'h1;
      for (int i = 0; i < 7; i++) begin
         if (i < int'(n)) begin
            p = 24'(p * 24'd10);
         end
      end
      return p;
   endfunction

   function automatic logic [3:0] ndigits(input logic [31:0] v);
      logic [3:0]  n;
      logic [33:0] p;
      n = 4'd1;
      p = 34'd10;
      for (int i = 0; i < 9; i++) begin
         if (34'(v) >= p) begin
            n = 4'(n + 4'd1);
         end
         p = 34'(p * 34'd10);
      end
      return n;
   endfunction

   wire logic       analog  = ctrl[frm_pkg::SEL_BIT];
   wire logic [1:0] tb      = ctrl[frm_pkg::TB_LSB +: 2];
   wire logic       auto_en = ctrl[frm_pkg::AUTO_BIT];
   wire logic [2:0] dp      = ctrl[frm_pkg::DP_LSB +: 3];
   wire logic       edge_in = pulse_in & ~pulse_d;
   wire logic       start   = batch_start | auto_start;
   wire logic       cut     = fch.y < cutoff;
   wire logic       low     = fch.y < alarm_sp;

   // Register writes, with settings held to their legal ranges
   always_ff @(posedge clk) begin
      if (rst) begin
         ctrl     <= frm_pkg::CTRL_RST;
         vol_rcp  <= frm_pkg::ONE_Q20;
         rscale   <= frm_pkg::ONE_Q12;
         full20   <= frm_pkg::ONE_Q12;
         alarm_sp <= 32'h0;
         cutoff   <= 32'h0;
         holdoff  <= 12'(frm_pkg::MIN_HOLDOFF);
         cycles   <= 14'h1;
         rdelay   <= 17'h0;
         route    <= '0;
         irq_mask <= '0;
      end else if (ce && wr) begin
         unique case (addr)
            frm_pkg::A_CTRL: begin
               ctrl <= {3'(clamp(32'(wdata[14:12]), 32'h0, frm_pkg::MAX_DP)),
                        4'(clamp(32'(wdata[11:8]), 32'h0, frm_pkg::MAX_SETTING)),
                        4'(clamp(32'(wdata[7:4]), 32'h0, frm_pkg::MAX_SETTING)),
                        wdata[3:0]};
            end
            frm_pkg::A_VOL_RCP:  vol_rcp  <= wdata;
            frm_pkg::A_RSCALE:   rscale   <= wdata;
            frm_pkg::A_FULL20:   full20   <= wdata;
            frm_pkg::A_ALARM_SP: alarm_sp <= wdata;
            frm_pkg::A_CUTOFF:   cutoff   <= wdata;
            frm_pkg::A_HOLDOFF: begin
               holdoff <= 12'(clamp(wdata, frm_pkg::MIN_HOLDOFF, frm_pkg::MAX_HOLDOFF));
            end
            frm_pkg::A_CYCLES: begin
               cycles <= 14'(clamp(wdata, 32'h1, frm_pkg::MAX_CYCLES));
            end
            frm_pkg::A_RDELAY: begin
               rdelay <= 17'(clamp(wdata, 32'h0, frm_pkg::MAX_RDELAY));
            end
            frm_pkg::A_ROUTE:    route    <= wdata[NSW-1:0];
            frm_pkg::A_MASK:     irq_mask <= wdata[frm_pkg::ST_W-1:0];
            default: begin
            end
         endcase
      end
   end

   // Register reads, data in the following cycle
   always_ff @(posedge clk) begin
      if (rst) begin
         rdata <= 32'h0;
      end else if (ce) begin
         rdata <= 32'h0;
         if (rd) begin
            unique case (addr)
               frm_pkg::A_CTRL:     rdata <= 32'(ctrl);
               frm_pkg::A_VOL_RCP:  rdata <= vol_rcp;
               frm_pkg::A_RSCALE:   rdata <= rscale;
               frm_pkg::A_FULL20:   rdata <= full20;
               frm_pkg::A_ALARM_SP: rdata <= alarm_sp;
               frm_pkg::A_CUTOFF:   rdata <= cutoff;
               frm_pkg::A_HOLDOFF:  rdata <= 32'(holdoff);
               frm_pkg::A_CYCLES:   rdata <= 32'(cycles);
               frm_pkg::A_RDELAY:   rdata <= 32'(rdelay);
               frm_pkg::A_ROUTE:    rdata <= 32'(route);
               frm_pkg::A_STATUS:   rdata <= 32'(status);
               frm_pkg::A_MASK:     rdata <= 32'(irq_mask);
               frm_pkg::A_RATE:     rdata <= rate_value;
               frm_pkg::A_TOT_LO:   rdata <= total[31:0];
               frm_pkg::A_TOT_HI:   rdata <= 32'(total[47:32]);
               frm_pkg::A_SEQ:      rdata <= {running, low_flow_pause, 2'(seq), 14'h0, done_cnt};
               frm_pkg::A_DISP:     rdata <= rate_disp;
               default:             rdata <= 32'h0;
            endcase
         end
      end
   end

   // Sticky events, cleared by a status read; a new event wins over the clear
   always_comb begin
      ev = '0;
      ev[frm_pkg::ST_LOWFLOW] = low_flow_pause == 1'b0 && running && hold_cnt == 12'h0 && low;
      ev[frm_pkg::ST_AUTOST]  = auto_start;
      ev[frm_pkg::ST_CYCDONE] = seq == frm_pkg::SEQ_RUN && batch_done && auto_en &&
                                14'(done_cnt + 14'h1) >= cycles;
      ev[frm_pkg::ST_CUTOFF]  = cut && !cut_d;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         status <= '0;
         irq    <= 1'b0;
         cut_d  <= 1'b0;
      end else if (ce) begin
         status <= ((rd && addr == frm_pkg::A_STATUS) ? '0 : status) | ev;
         irq    <= |(status & irq_mask);
         cut_d  <= cut;
      end
   end

   // Second and filter ticks
   always_ff @(posedge clk) begin
      if (rst) begin
         sec_cnt   <= 32'h0;
         filt_cnt  <= 32'h0;
         sec_tick  <= 1'b0;
         filt_tick <= 1'b0;
      end else if (ce) begin
         sec_tick  <= sec_cnt == 32'(SEC_CYC - 1);
         filt_tick <= filt_cnt == 32'(FILT_CYC - 1);
         sec_cnt   <= (sec_cnt == 32'(SEC_CYC - 1)) ? 32'h0 : 32'(sec_cnt + 32'h1);
         filt_cnt  <= (filt_cnt == 32'(FILT_CYC - 1)) ? 32'h0 : 32'(filt_cnt + 32'h1);
      end
   end

   // Rate measurement: pulses per second, or the loop current
   logic [55:0] p_vol;
   logic [63:0] p_scl;
   logic [43:0] p_tb;
   logic [ADC_W-1:0] span;
   logic [95:0] a_prod;

   always_comb begin
      p_vol  = 56'(pcnt) * 56'(vol_rcp);
      p_scl  = 64'(p_vol[39:8]) * 64'(rscale);
      unique case (tb)
         frm_pkg::TB_MIN: p_tb = 44'(p_scl[43:12]) * 44'(frm_pkg::TB_MIN_MUL);
         frm_pkg::TB_HR:  p_tb = 44'(p_scl[43:12]) * 44'(frm_pkg::TB_HR_MUL);
         default:         p_tb = 44'(p_scl[43:12]);
      endcase
      span   = (adc_code > ADC_W'(CODE_4MA)) ? ADC_W'(adc_code - ADC_W'(CODE_4MA)) : '0;
      a_prod = 96'(span) * 96'(full20) * 96'(INV_SPAN);
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         pulse_d <= 1'b0;
         pcnt    <= '0;
         p_rate  <= 32'h0;
         a_rate  <= 32'h0;
      end else if (ce) begin
         pulse_d <= pulse_in;
         if (sec_tick) begin
            pcnt   <= CNT_W'(edge_in);
            p_rate <= p_tb[31:0];
         end else if (edge_in) begin
            pcnt <= CNT_W'(pcnt + CNT_W'(1));
         end
         if (filt_tick) begin
            // Over-range reads full scale; also hides the truncated span reciprocal at 20mA
            a_rate <= (adc_code >= ADC_W'(CODE_20MA)) ? full20 : a_prod[55:24];
         end
      end
   end

   assign fch.tick   = filt_tick & ce;
   assign fch.x      = analog ? a_rate : p_rate;
   assign fch.smooth = ctrl[frm_pkg::SM_LSB +: 4];
   assign fch.jump   = ctrl[frm_pkg::JO_LSB +: 4];

   rate_filter u_filt (
      .clk (clk),
      .rst (rst),
      .ce  (ce),
      .f   (fch)
   );

   // Presented rate and its decimal representation
   logic [55:0] disp_prod;
   always_comb begin
      disp_prod = 56'(rate_value) * 56'(pow10(dp));
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         rate_value  <= 32'h0;
         rate_disp   <= 32'h0;
         rate_digits <= 4'd1;
      end else if (ce) begin
         rate_value  <= cut ? 32'h0 : fch.y;
         rate_disp   <= disp_prod[43:12];
         // Digits shown: never fewer than one left of the point
         rate_digits <= (ndigits(rate_disp) > 4'(dp)) ? ndigits(rate_disp) : 4'(4'(dp) + 4'd1);
      end
   end

   // Batch total
   logic [63:0] a_inc;
   logic [55:0] a_tb;
   always_comb begin
      a_inc = 64'(fch.y) * 64'(vol_rcp);
      unique case (tb)
         frm_pkg::TB_MIN: a_tb = 56'(a_inc[43:12]) * 56'(frm_pkg::TB_RCP_MIN);
         frm_pkg::TB_HR:  a_tb = 56'(a_inc[43:12]) * 56'(frm_pkg::TB_RCP_HR);
         default:         a_tb = 56'(a_inc[43:12]) * 56'(frm_pkg::TB_RCP_SEC);
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         total <= 48'h0;
      end else if (ce) begin
         if (start) begin
            total <= 48'h0;
         end else if (running && !cut && !low_flow_pause) begin
            if (!analog && edge_in) begin
               total <= 48'(total + 48'(vol_rcp));
            end else if (analog && sec_tick) begin
               total <= 48'(total + 48'(a_tb[55:24]));
            end
         end
      end
   end

   // Low-flow supervision with start-up hold-off
   always_ff @(posedge clk) begin
      if (rst) begin
         hold_cnt       <= 12'h0;
         low_flow_pause <= 1'b0;
         alarm_sw       <= '0;
      end else if (ce) begin
         if (start) begin
            hold_cnt       <= holdoff;
            low_flow_pause <= 1'b0;
            alarm_sw       <= '0;
         end else begin
            if (sec_tick && hold_cnt != 12'h0) begin
               hold_cnt <= 12'(hold_cnt - 12'h1);
            end
            if (batch_done) begin
               low_flow_pause <= 1'b0;
               alarm_sw       <= '0;
            end else if (ev[frm_pkg::ST_LOWFLOW]) begin
               low_flow_pause <= 1'b1;
               alarm_sw       <= route;
            end
         end
      end
   end

   // Batch sequencing and automatic restart
   always_ff @(posedge clk) begin
      if (rst) begin
         seq        <= frm_pkg::SEQ_IDLE;
         running    <= 1'b0;
         done_cnt   <= 14'h0;
         dly_cnt    <= 17'h0;
         auto_start <= 1'b0;
      end else if (ce) begin
         auto_start <= 1'b0;
         if (start) begin
            seq     <= frm_pkg::SEQ_RUN;
            running <= 1'b1;
            if (batch_start) begin
               done_cnt <= 14'h0;
            end
         end else begin
            unique case (seq)
               frm_pkg::SEQ_IDLE: begin
               end
               frm_pkg::SEQ_RUN: begin
                  if (batch_done) begin
                     running  <= 1'b0;
                     done_cnt <= 14'(done_cnt + 14'h1);
                     dly_cnt  <= 17'h0;
                     if (auto_en && 14'(done_cnt + 14'h1) < cycles) begin
                        seq <= frm_pkg::SEQ_DELAY;
                     end else begin
                        seq <= frm_pkg::SEQ_IDLE;
                     end
                  end
               end
               frm_pkg::SEQ_DELAY: begin
                  if (dly_cnt >= rdelay) begin
                     auto_start <= 1'b1;
                  end else if (sec_tick) begin
                     dly_cnt <= 17'(dly_cnt + 17'h1);
                  end
               end
            endcase
         end
      end
   end
endmodule

// >>> verif/flow_source.sv
module flow_source (
   // Clock and pacing
   input  wire logic       clk,
   input  wire logic [7:0] period,
   input  wire logic       full,
   // Meter outputs
   output logic            pulse_in,
   output logic [15:0]     adc_code
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] cnt = 8'h00;
   initial pulse_in = 1'b0;
   // A zero period stops the meter, so no pulse edge appears at all
   always @(posedge clk) begin
      cnt <= (cnt + 8'h01 >= period) ? 8'h00 : cnt + 8'h01;
      pulse_in <= (period != 8'h00) && (cnt < period / 2);
   end
   // Loop current at either end of its span
   assign adc_code = full ? 16'h4000 : 16'h0ccd;
endmodule

// >>> verif/frm_asserts.sv
module frm_asserts #(
   parameter int NSW = 6
) (
   // Clock and controls
   input wire logic           clk,
   input wire logic           rst,
   input wire logic           ce,
   input wire logic           batch_start,
   input wire logic           batch_done,
   input wire logic           rd,
   // Observed outputs
   input wire logic [31:0]    rdata,
   input wire logic [31:0]    rate_value,
   input wire logic [31:0]    rate_disp,
   input wire logic [3:0]     rate_digits,
   input wire logic [47:0]    total,
   input wire logic [NSW-1:0] alarm_sw,
   input wire logic           low_flow_pause,
   input wire logic           auto_start
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // Starts come from the operator or from the restart sequencer
   sequence s_start;
      (batch_start || auto_start) && ce;
   endsequence
   sequence s_quiet2;
      !low_flow_pause [*2];
   endsequence
   AST_RDATA_IDLE: assert property (!$past(rd) |-> rdata == 32'h0)
      else $error("read data not zero outside a read answer");
   AST_START_CLEAR: assert property (s_start |=> total == 48'h0)
      else $error("total not cleared by batch start");
   AST_HOLDOFF: assert property (s_start |=> s_quiet2)
      else $error("low flow pause right after batch start");
   AST_DONE_CLEARS: assert property (batch_done && ce |=> !low_flow_pause)
      else $error("pause kept after batch done");
   AST_ROUTE: assert property (!low_flow_pause |-> alarm_sw == '0)
      else $error("alarm output closed without pause");
   AST_AUTO_PULSE: assert property (auto_start |=> !auto_start)
      else $error("auto start longer than one cycle");
   AST_FREEZE: assert property (!ce |=> $stable(total) && $stable(rate_value))
      else $error("state moved while clock enable low");
   AST_DIGITS: assert property ($past(ce) && $past(rate_disp) >= 32'h2710 |->
      rate_digits >= 4'h5)
      else $error("rate shown with significant digits lost");
endmodule
bind flow_rate_monitor frm_asserts #(.NSW(NSW)) frm_asserts_i (
   .clk(clk), .rst(rst), .ce(ce), .batch_start(batch_start), .batch_done(batch_done),
   .rd(rd), .rdata(rdata), .rate_value(rate_value), .rate_disp(rate_disp),
   .rate_digits(rate_digits),
   .total(total), .alarm_sw(alarm_sw), .low_flow_pause(low_flow_pause),
   .auto_start(auto_start));

// >>> verif/tb_flow_rate_monitor.sv
module tb_flow_rate_monitor;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {logic [7:0] a; logic [31:0] r, w, e;} reg_s;
   typedef struct {logic [31:0] c; logic f; logic [31:0] v, d; logic [3:0] n;} rate_s;
   logic        clk = 1'b0, rst = 1'b1, ce = 1'b1, full = 1'b0, wr = 1'b0, rd = 1'b0;
   logic        batch_start = 1'b0, batch_done = 1'b0, pulse_in, irq, low_flow_pause;
   logic        auto_start;
   logic [7:0]  addr = 8'h00, period = 8'h0a;
   logic [15:0] adc_code;
   logic [31:0] wdata = 32'h0, rdata, rate_value, rate_disp;
   logic [3:0]  rate_digits;
   logic [47:0] total;
   logic [5:0]  alarm_sw;
   int          errors = 0, compares = 0;
   // Reset value, value written, value read back after clamping
   reg_s regs [10] = '{'{frm_pkg::A_CTRL, 32'h0, 32'h0, 32'h0},
      '{frm_pkg::A_VOL_RCP, 32'h00100000, 32'h00100000, 32'h00100000},
      '{frm_pkg::A_RSCALE, 32'h1000, 32'h1000, 32'h1000},
      '{frm_pkg::A_FULL20, 32'h1000, 32'h3000, 32'h3000},
      '{frm_pkg::A_HOLDOFF, 32'h1, 32'h1388, 32'he10},
      '{frm_pkg::A_CYCLES, 32'h1, 32'h4e20, 32'h2710},
      '{frm_pkg::A_RDELAY, 32'h0, 32'h186a0, 32'h15180},
      '{frm_pkg::A_ROUTE, 32'h0, 32'h15, 32'h15},
      '{frm_pkg::A_MASK, 32'h0, 32'h0, 32'h0}, '{8'hfc, 32'h0, 32'hffffffff, 32'h0}};
   // Meter gives 5 pulses per 50-cycle second; pulse row last leaves ctrl at zero
   rate_s rates [6] = '{'{32'h5, 1'b1, 32'h3000, 32'h3, 4'h1},
      '{32'h1, 1'b0, 32'h0, 32'h0, 4'h1}, '{32'h2002, 1'b0, 32'h12c000, 32'h7530, 4'h5},
      '{32'h994, 1'b0, 32'h4650000, 32'h4650, 4'h5},
      '{32'h4, 1'b0, 32'h4650000, 32'h4650, 4'h5}, '{32'h0, 1'b0, 32'h5000, 32'h5, 4'h1}};
   flow_rate_monitor #(.SEC_CYC(50), .FILT_CYC(5)) flow_rate_monitor_i (
      .clk(clk), .rst(rst), .ce(ce), .pulse_in(pulse_in), .adc_code(adc_code),
      .batch_start(batch_start), .batch_done(batch_done), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .rate_value(rate_value), .rate_disp(rate_disp),
      .rate_digits(rate_digits), .total(total), .alarm_sw(alarm_sw),
      .low_flow_pause(low_flow_pause), .auto_start(auto_start), .irq(irq));
   flow_source flow_source_i (.clk(clk), .period(period), .full(full),
      .pulse_in(pulse_in), .adc_code(adc_code));
   always #4 clk = ~clk;
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      compares++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic stop_test;
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // Ends one step after the edge so outputs have settled
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 v = rdata;
   endtask
   task automatic strobe(input logic go);
      @(posedge clk);
      if (go) batch_start <= 1'b1;
      else batch_done <= 1'b1;
      @(posedge clk);
      batch_done <= 1'b0;
      batch_start <= 1'b0;
   endtask
   initial begin
      cyc(20000);
      errors++;
      stop_test();
   end
   initial begin
      logic [31:0] d;
      logic [47:0] t;
      logic [3:0]  seen;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      foreach (regs[i]) begin
         rd_reg(regs[i].a, d);
         check(d, regs[i].r);
         wr_reg(regs[i].a, regs[i].w);
         rd_reg(regs[i].a, d);
         check(d, regs[i].e);
      end
      foreach (rates[i]) begin
         wr_reg(frm_pkg::A_CTRL, rates[i].c);
         full <= rates[i].f;
         cyc(160);
         check(rate_value, rates[i].v);
         check(rate_disp, rates[i].d);
         check(rate_digits, rates[i].n);
      end
      wr_reg(frm_pkg::A_CTRL, 32'h94);
      cyc(160);
      check(rate_value > 32'h5000 && rate_value < 32'h4650000, 1'b1);
      wr_reg(frm_pkg::A_CTRL, 32'h0);
      cyc(60);
      $display("test registers and rates done");
      strobe(1'b1);
      cyc(100);
      check(total != 48'h0, 1'b1);
      @(posedge clk);
      ce <= 1'b0;
      #1 t = total;
      repeat (20) @(posedge clk);
      check(total, t);
      ce <= 1'b1;
      wr_reg(frm_pkg::A_CUTOFF, 32'ha000);
      cyc(160);
      t = total;
      check(rate_value, 32'h0);
      check(irq, 1'b0);
      cyc(100);
      check(total, t);
      wr_reg(frm_pkg::A_MASK, 32'h8);
      cyc(3);
      check(irq, 1'b1);
      rd_reg(frm_pkg::A_STATUS, d);
      check(d, 32'h8);
      cyc(3);
      check(irq, 1'b0);
      $display("test cut-off done");
      wr_reg(frm_pkg::A_CUTOFF, 32'h0);
      wr_reg(frm_pkg::A_ALARM_SP, 32'h64000);
      wr_reg(frm_pkg::A_HOLDOFF, 32'h2);
      strobe(1'b0);
      strobe(1'b1);
      cyc(45);
      check(low_flow_pause, 1'b0);
      for (int k = 0; k < 200 && low_flow_pause !== 1'b1; k++) cyc(1);
      check(low_flow_pause, 1'b1);
      check(alarm_sw, 6'h15);
      t = total;
      cyc(60);
      check(total, t);
      strobe(1'b0);
      cyc(2);
      check({low_flow_pause, alarm_sw}, 7'h0);
      $display("test low flow done");
      wr_reg(frm_pkg::A_ALARM_SP, 32'h0);
      wr_reg(frm_pkg::A_CYCLES, 32'h2);
      wr_reg(frm_pkg::A_RDELAY, 32'h0);
      wr_reg(frm_pkg::A_CTRL, 32'h8);
      strobe(1'b1);
      cyc(5);
      strobe(1'b0);
      cyc(1);
      check(auto_start, 1'b1);
      cyc(5);
      strobe(1'b0);
      seen = 4'h0;
      repeat (10) begin
         cyc(1);
         seen += auto_start;
      end
      check(seen, 4'h0);
      rd_reg(frm_pkg::A_STATUS, d);
      check(d, 32'h7);
      $display("test auto restart done");
      wr_reg(frm_pkg::A_CTRL, 32'h3);
      full <= 1'b1;
      cyc(60);
      strobe(1'b1);
      for (int k = 0; k < 100 && total == 48'h0; k++) cyc(1);
      check(total, 48'hcccc);
      $display("test analogue total done");
      stop_test();
   end
endmodule
